// ---- design/dioprt_pkg.sv ----
// Package of offsets, reset values and phases for the digital I/O port block
package dioprt_pkg;
	localparam int unsigned PORT_W    = 8;
	localparam int unsigned NUM_PORTS = 7;
	localparam logic [7:0] OFS_PORT_ZERO   = 8'h80;
	localparam logic [7:0] OFS_PORT_ONE    = 8'h90;
	localparam logic [7:0] OFS_PORT_TWO    = 8'ha0;
	localparam logic [7:0] OFS_PORT_THREE  = 8'hb0;
	localparam logic [7:0] OFS_COMPARE     = 8'he8;
	localparam logic [7:0] OFS_CONC_CMP    = 8'hf8;
	localparam logic [7:0] OFS_SERIAL_AUX  = 8'hfa;
	localparam logic [7:0] OFS_ANALOG_LOW  = 8'hdb;
	localparam logic [7:0] OFS_ANALOG_HIGH = 8'hdd;
	localparam logic [7:0] RST_PORT_LATCH  = 8'hff;
	localparam logic [7:0] ANALOG_HIGH_MASK = 8'h0f;
	typedef enum logic [1:0] {
		DIOPRT_IDLE,
		DIOPRT_ADDR,
		DIOPRT_DATA
	} dioprt_phase_t;
endpackage

// ---- design/dioprt_bit_port.sv ----
// One bidirectional port: latch, driver and input buffer for each bit
`timescale 1ns/100ps
module dioprt_bit_port #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// Register write
	input  wire logic             i_wr,
	input  wire logic [WIDTH-1:0] i_wdata,
	// Pin side
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_latch,
	output logic      [WIDTH-1:0] o_pin_in
);
	logic [WIDTH-1:0] latch_r;
	logic [WIDTH-1:0] latch_nxt;
	logic [WIDTH-1:0] in_r;

	initial begin
		if (WIDTH == 0 || WIDTH > dioprt_pkg::PORT_W) $error("dioprt_bit_port: WIDTH must be 1 to 8");
	end

	always_comb begin
		latch_nxt = latch_r;
		if (i_wr) begin
			latch_nxt = i_wdata; // (R3)
		end
	end

	// Latch per bit, input buffer per bit
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			latch_r <= dioprt_pkg::RST_PORT_LATCH[WIDTH-1:0];
			in_r    <= '0;
		end else begin
			latch_r <= latch_nxt; // (R2)
			in_r    <= i_pin; // (R2)
		end
	end

	assign o_latch  = latch_r;
	assign o_pin_in = in_r;
endmodule

// ---- design/dioprt_top.sv ----
// Digital I/O port block: seven bidirectional ports, two input ports, external memory sharing
//
// Overview of operation
// (R1) Seven eight-bit ports, each line input or output; every line is driven except port zero in a read data phase
// (R2) Each bit has latch, driver, input buffer
// (R3) Port register write sets latch, read returns pins
// (R4) External memory reuses port zero/two drivers
// (R5) Port zero sends address low, then data
// (R6) Port two high address only for 16-bit
// (R7) Input-only port writes ignored, reads return pins
// (R8) Idle ports zero and two drive latches
`timescale 1ns/100ps
module dioprt_top #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// Special function register port
	input  wire logic [7:0]       i_sfr_addr,
	input  wire logic             i_sfr_wr,
	input  wire logic             i_sfr_rd,
	input  wire logic [WIDTH-1:0] i_sfr_wdata,
	output logic      [WIDTH-1:0] o_sfr_rdata,
	output logic                  o_sfr_hit,
	// External memory request
	input  wire logic             i_xm_start,
	input  wire logic             i_xm_wide,
	input  wire logic             i_xm_write,
	input  wire logic [15:0]      i_xm_addr,
	input  wire logic [WIDTH-1:0] i_xm_wdata,
	output logic                  o_xm_busy,
	output logic                  o_xm_ale,
	output logic                  o_xm_done,
	output logic      [WIDTH-1:0] o_xm_rdata,
	// Bidirectional port pins, seven ports packed low port first
	input  wire logic [7*WIDTH-1:0] i_port_pin,
	output logic      [7*WIDTH-1:0] o_port_pin,
	output logic      [7*WIDTH-1:0] o_port_oe_n,
	// Input-only ports
	input  wire logic [WIDTH-1:0] i_analog_low,
	input  wire logic [WIDTH-1:0] i_analog_high
);
	localparam int unsigned NP = dioprt_pkg::NUM_PORTS;

	initial begin
		if (WIDTH != dioprt_pkg::PORT_W) $error("dioprt_top: WIDTH must be 8");
		if (NP != 7) $error("dioprt_top: the pin buses hold exactly seven ports");
	end

	logic [WIDTH-1:0] wsel_latch [NP];
	logic [WIDTH-1:0] pin_in     [NP];
	logic [NP-1:0]    port_wr;

	// Register offset of each bidirectional port, low port first
	function automatic logic [7:0] port_ofs(input int unsigned k);
		case (k)
			0:       port_ofs = dioprt_pkg::OFS_PORT_ZERO;
			1:       port_ofs = dioprt_pkg::OFS_PORT_ONE;
			2:       port_ofs = dioprt_pkg::OFS_PORT_TWO;
			3:       port_ofs = dioprt_pkg::OFS_PORT_THREE;
			4:       port_ofs = dioprt_pkg::OFS_COMPARE;
			5:       port_ofs = dioprt_pkg::OFS_CONC_CMP;
			default: port_ofs = dioprt_pkg::OFS_SERIAL_AUX;
		endcase
	endfunction

	// One decode of the register address, shared by writes and reads
	logic [NP-1:0] port_sel;
	always_comb begin
		for (int unsigned k = 0; k < NP; k++) begin
			port_sel[k] = (i_sfr_addr == port_ofs(k));
		end
	end

	// Seven independent ports
	for (genvar g = 0; g < NP; g++) begin : g_port
		assign port_wr[g] = i_sfr_wr && port_sel[g]; // (R3)
		dioprt_bit_port #(.WIDTH(WIDTH)) u_port ( // (R1)
			.i_clk    (i_clk),
			.i_rstn   (i_rstn),
			.i_wr     (port_wr[g]),
			.i_wdata  (i_sfr_wdata),
			.i_pin    (i_port_pin[g*WIDTH +: WIDTH]),
			.o_latch  (wsel_latch[g]),
			.o_pin_in (pin_in[g])
		);
	end

	// External memory sequencer
	// A start while busy is dropped without notice, so the core must wait for done
	dioprt_pkg::dioprt_phase_t phase_r;
	dioprt_pkg::dioprt_phase_t phase_nxt;
	logic [15:0]      addr_r;
	logic [15:0]      addr_nxt;
	logic [WIDTH-1:0] wdat_r;
	logic [WIDTH-1:0] wdat_nxt;
	logic             wide_r;
	logic             wide_nxt;
	logic             wr_r;
	logic             wr_nxt;
	logic [WIDTH-1:0] rdat_r;
	logic [WIDTH-1:0] rdat_nxt;
	logic             done_r;
	logic             done_nxt;

	always_comb begin
		phase_nxt = phase_r;
		addr_nxt  = addr_r;
		wdat_nxt  = wdat_r;
		wide_nxt  = wide_r;
		wr_nxt    = wr_r;
		rdat_nxt  = rdat_r;
		done_nxt  = 1'b0;
		case (phase_r)
			dioprt_pkg::DIOPRT_IDLE: begin
				// Fields are held for the whole access, so the core may move its inputs
				if (i_xm_start) begin
					phase_nxt = dioprt_pkg::DIOPRT_ADDR;
					addr_nxt  = i_xm_addr;
					wdat_nxt  = i_xm_wdata;
					wide_nxt  = i_xm_wide;
					wr_nxt    = i_xm_write;
				end
			end
			dioprt_pkg::DIOPRT_ADDR: begin
				phase_nxt = dioprt_pkg::DIOPRT_DATA; // (R5)
			end
			dioprt_pkg::DIOPRT_DATA: begin
				// The read byte is taken straight from the port zero pins, not from its input buffer
				// The far side still drives it at this edge
				if (!wr_r) begin
					rdat_nxt = i_port_pin[WIDTH-1:0]; // (R4)
				end
				done_nxt  = 1'b1;
				phase_nxt = dioprt_pkg::DIOPRT_IDLE;
			end
			default: phase_nxt = dioprt_pkg::DIOPRT_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_r <= dioprt_pkg::DIOPRT_IDLE;
			addr_r  <= 16'h0000;
			wdat_r  <= '0;
			wide_r  <= 1'b0;
			wr_r    <= 1'b0;
			rdat_r  <= '0;
			done_r  <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			addr_r  <= addr_nxt;
			wdat_r  <= wdat_nxt;
			wide_r  <= wide_nxt;
			wr_r    <= wr_nxt;
			rdat_r  <= rdat_nxt;
			done_r  <= done_nxt;
		end
	end

	// Done comes from a flip-flop, so it is a clean one-cycle pulse
	logic xm_act;
	assign xm_act     = (phase_r != dioprt_pkg::DIOPRT_IDLE);
	assign o_xm_busy  = xm_act;
	assign o_xm_ale   = (phase_r == dioprt_pkg::DIOPRT_ADDR);
	assign o_xm_done  = done_r;
	assign o_xm_rdata = rdat_r;

	// Pin drive; each pin starts from its latch and the access overrides port zero and, when wide, port two, only port zero in a read data phase is released
	always_comb begin
		for (int k = 0; k < NP; k++) begin
			o_port_pin[k*WIDTH +: WIDTH]  = wsel_latch[k]; // (R8)
			o_port_oe_n[k*WIDTH +: WIDTH] = '0; // (R2)
		end
		// Port zero belongs to the access in its address and data phases
		case (phase_r)
			dioprt_pkg::DIOPRT_ADDR: begin
				o_port_pin[WIDTH-1:0] = addr_r[7:0]; // (R5)
			end
			dioprt_pkg::DIOPRT_DATA: begin
				o_port_pin[WIDTH-1:0] = wdat_r; // (R5)
				// Release port zero so the read byte can come in
				o_port_oe_n[WIDTH-1:0] = {WIDTH{!wr_r}}; // (R4)
			end
			default: begin
				// Idle keeps the latch values set above
			end
		endcase

		// A narrow access leaves port two on its latch, so it stays usable as I/O
		if (xm_act && wide_r) begin
			o_port_pin[2*WIDTH +: WIDTH] = addr_r[15:8]; // (R6)
		end
	end

	// Read mux; ports read their pin levels, input-only ports have no storage
	// A bidirectional port read goes through the input buffer, so a pin change shows one clock later
	always_comb begin
		o_sfr_rdata = '0;
		o_sfr_hit   = 1'b0;
		for (int k = 0; k < NP; k++) begin
			if (port_sel[k]) begin
				o_sfr_rdata = pin_in[k]; // (R3)
				o_sfr_hit   = 1'b1;
			end
		end

		// Input-only ports have no latch, so a write to them finds nothing to change
		if (i_sfr_addr == dioprt_pkg::OFS_ANALOG_LOW) begin
			o_sfr_rdata = i_analog_low; // (R7)
			o_sfr_hit   = 1'b1;
		end else if (i_sfr_addr == dioprt_pkg::OFS_ANALOG_HIGH) begin
			o_sfr_rdata = i_analog_high & dioprt_pkg::ANALOG_HIGH_MASK; // (R7)
			o_sfr_hit   = 1'b1;
		end
		if (!i_sfr_rd) begin
			o_sfr_rdata = '0;
		end
	end
endmodule

// ---- test/dioprt_sva.sv ----
// Checker of the port block top ports
`timescale 1ns/100ps
module dioprt_sva (
	input wire logic        i_clk, i_rstn, i_sfr_wr, i_sfr_rd, i_xm_start, i_xm_wide, i_xm_write,
	input wire logic        o_sfr_hit, o_xm_busy, o_xm_ale, o_xm_done,
	input wire logic [7:0]  i_sfr_addr, i_sfr_wdata, i_xm_wdata, o_sfr_rdata, i_analog_low,
	input wire logic [15:0] i_xm_addr,
	input wire logic [55:0] o_port_pin, o_port_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_take; i_xm_start && !o_xm_busy; endsequence
	sequence s_walk; o_xm_ale && o_xm_busy ##1 !o_xm_ale && o_xm_busy ##1 o_xm_done && !o_xm_busy; endsequence
	a_xm_walk: assert property (s_take |=> s_walk) else $error("bad phases");
	a_addr_low: assert property (s_take |=> o_port_pin[7:0] == $past(i_xm_addr[7:0])) else $error("bad addr");
	a_data_out: assert property ((s_take and i_xm_write) |=> ##1 o_port_pin[7:0] == $past(i_xm_wdata, 2))
		else $error("bad data");
	a_wide_high: assert property ((s_take and i_xm_wide) |=> o_port_pin[23:16] == $past(i_xm_addr[15:8])
		##1 o_port_pin[23:16] == $past(i_xm_addr[15:8], 2)) else $error("bad high");
	a_narrow_latch: assert property ((s_take and !i_xm_wide) |=> $stable(o_port_pin[23:16]) [*2])
		else $error("high moved");
	a_read_release: assert property ((s_take and !i_xm_write) |=> ##1 o_port_oe_n[7:0] == 8'hff)
		else $error("not released");
	a_idle_drive: assert property (!o_xm_busy |-> o_port_oe_n == '0) else $error("idle undriven");
	a_reg_write: assert property (i_sfr_wr && i_sfr_addr == dioprt_pkg::OFS_COMPARE
		|=> o_port_pin[39:32] == $past(i_sfr_wdata)) else $error("latch lost");
	a_input_read: assert property (i_sfr_rd && i_sfr_addr == dioprt_pkg::OFS_ANALOG_LOW
		|-> o_sfr_rdata == i_analog_low) else $error("bad input");
endmodule
bind dioprt_top dioprt_sva u_sva (.*);

// ---- test/dioprt_board.sv ----
// Board model: pins loop back, external memory on ports zero and two
`timescale 1ns/100ps
module dioprt_board (
	input wire logic        i_clk,
	input wire logic        o_xm_ale,
	input wire logic [55:0] o_port_pin,
	input wire logic [55:0] o_port_oe_n,
	output logic     [55:0] i_port_pin
);
	logic [7:0]  mem [0:65535];
	logic [15:0] a_r;
	logic        ph_r = 1'b0;
	// Address from both ports in the address phase, data on port zero after it
	always @(posedge i_clk) begin
		if (o_xm_ale) a_r <= {o_port_pin[23:16], o_port_pin[7:0]};
		if (ph_r && o_port_oe_n[7:0] == 8'h00) mem[a_r] <= o_port_pin[7:0];
		ph_r <= o_xm_ale;
	end
	// A released port zero line outside a read shows the inverse, so stale data never passes; other released lines show zero
	assign i_port_pin = (o_port_pin & ~o_port_oe_n)
		| ({48'h0, ph_r ? mem[a_r] : ~o_port_pin[7:0]} & o_port_oe_n);
endmodule

// ---- test/tb.sv ----
// Self-checking bench of the digital port block
`timescale 1ns/100ps
module tb;
	logic i_clk = 0, i_rstn = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_xm_start = 0, i_xm_wide = 0, i_xm_write = 0;
	logic [7:0]  i_sfr_addr = '0, i_sfr_wdata = '0, i_xm_wdata = '0, i_analog_low = '0, i_analog_high = '0;
	logic [15:0] i_xm_addr = '0, a;
	logic [7:0]  o_sfr_rdata, o_xm_rdata, d;
	logic        o_sfr_hit, o_xm_busy, o_xm_ale, o_xm_done;
	logic [55:0] i_port_pin, o_port_pin, o_port_oe_n;
	logic [7:0]  lat [7];
	logic [7:0]  ofs [7] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'he8, 8'hf8, 8'hfa};
	int          fail_count = 0, checks = 0, seed = 32'h9013, cyc = 0;
	dioprt_top dut (.*);
	dioprt_board u_board (.*);
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	function automatic logic [7:0] hi_exp(logic [7:0] v);
		return v & dioprt_pkg::ANALOG_HIGH_MASK;
	endfunction
	task automatic cmp(logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(logic [7:0] ad, logic [7:0] v);
		@(posedge i_clk);
		i_sfr_addr <= ad;
		i_sfr_wdata <= v;
		i_sfr_wr <= 1'b1;
		i_sfr_rd <= 1'b0;
		@(posedge i_clk);
		i_sfr_wr <= 1'b0;
	endtask
	task automatic rd_chk(logic [7:0] ad, logic [7:0] e);
		@(posedge i_clk);
		i_sfr_addr <= ad;
		i_sfr_rd <= 1'b1;
		@(negedge i_clk);
		cmp(e, o_sfr_rdata);
	endtask
	// Start stands for one edge; done is looked at just after the edge that raises it
	task automatic xm(logic w, logic wide, logic [15:0] ad, logic [7:0] v);
		@(posedge i_clk);
		i_xm_start <= 1'b1;
		i_xm_write <= w;
		i_xm_wide <= wide;
		i_xm_addr <= ad;
		i_xm_wdata <= v;
		@(posedge i_clk);
		i_xm_start <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		cmp(8'h01, {7'h0, o_xm_done});
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		for (int k = 0; k < 7; k++) rd_chk(ofs[k], dioprt_pkg::RST_PORT_LATCH);
		for (int k = 0; k < 7; k++) begin
			lat[k] = (k == 1) ? 8'h00 : $random(seed);
			wr(ofs[k], lat[k]);
			rd_chk(ofs[k], lat[k]);
			cmp(lat[k], o_port_pin[8*k+:8]);
		end
		@(posedge i_clk);
		i_analog_low <= $random(seed);
		i_analog_high <= $random(seed);
		wr(dioprt_pkg::OFS_ANALOG_LOW, 8'h3c);
		rd_chk(dioprt_pkg::OFS_ANALOG_LOW, i_analog_low);
		rd_chk(dioprt_pkg::OFS_ANALOG_HIGH, hi_exp(i_analog_high));
		cmp(8'h01, {7'h0, o_sfr_hit});
		rd_chk(8'h81, 8'h00);
		cmp(8'h00, {7'h0, o_sfr_hit});
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			a = (k == 3) ? 16'hffff : $random(seed);
			xm(1'b1, k[0], a, d);
			xm(1'b0, k[0], a, 8'h00);
			cmp(d, o_xm_rdata);
			cmp(lat[0], o_port_pin[7:0]);
			cmp(lat[2], o_port_pin[23:16]);
		end
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		cmp(8'h00, o_xm_rdata);
		for (int k = 0; k < 7; k++) rd_chk(ofs[k], dioprt_pkg::RST_PORT_LATCH);
		report_and_stop();
	end
	task automatic report_and_stop();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
endmodule
